// File: verilog/sfw_watchdog.sv
// software fault watchdog core with its register slave
`timescale 1ns/1ps
`default_nettype none
`include "sfw_consts.svh"

module sfw_watchdog #(
  parameter int unsigned PRESC_DIV = `SFW_PRESC_CYCLES,
  parameter int unsigned PULSE_LEN = `SFW_PULSE_CYC
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic awvalid,
  output logic awready,
  input wire logic [`SFW_ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [`SFW_ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // oscillator and option pins
  input wire logic divided_osc_clock,
  input wire logic hw_watchdog_option,
  input wire logic halt_reset_option,
  input wire logic long_startup_option,
  // cpu events, same clock
  input wire logic cpu_halt,
  input wire logic ext_irq,
  input wire logic osc_irq,
  // reset pin
  output logic reset_pin_n
);
  import sfw_pkg::*;

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  function automatic logic sfw_sel(input logic [`SFW_ADDR_W-1:0] a,
                                   input logic [`SFW_ADDR_W-1:0] off);
    sfw_sel = (a[`SFW_ADDR_W-1:2] == off[`SFW_ADDR_W-1:2]);
  endfunction : sfw_sel

  function automatic logic [5:0] sfw_tb_msb(input sfw_tb_t tb);
    case (tb)
      2'h0: sfw_tb_msb = `SFW_TB0_MSB;
      2'h1: sfw_tb_msb = `SFW_TB1_MSB;
      2'h2: sfw_tb_msb = `SFW_TB2_MSB;
      default: sfw_tb_msb = `SFW_TB3_MSB;
    endcase
  endfunction : sfw_tb_msb

  function automatic logic [5:0] sfw_tb_lsb(input sfw_tb_t tb);
    case (tb)
      2'h0: sfw_tb_lsb = `SFW_TB0_LSB;
      2'h1: sfw_tb_lsb = `SFW_TB1_LSB;
      2'h2: sfw_tb_lsb = `SFW_TB2_LSB;
      default: sfw_tb_lsb = `SFW_TB3_LSB;
    endcase
  endfunction : sfw_tb_lsb

  // --------------------------------------------------------------
  // declarations
  // --------------------------------------------------------------
  sfw_link_if lk ();

  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [`SFW_ADDR_W-1:0] awaddr_q;
  logic [7:0] wdata_q;
  logic wlane_q;
  logic [2:0] opt_s1_q;
  logic [2:0] opt_s2_q;
  logic active_q;
  logic [6:0] count_q;
  logic [2:0] mode_q;
  sfw_state_t st_q;
  sfw_state_t st_d;
  logic [12:0] wait_q;
  logic fire_q;
  logic reset_pin_n_q;
  logic do_write;
  logic wr_guard;
  logic wr_mode;
  logic hw_opt;
  logic halt_opt;
  logic long_opt;
  logic active_eff;
  logic step;
  logic wait_done;
  logic [31:0] rd_mux;
  logic rd_ok;
  logic [15:0] tmin0;

  // --------------------------------------------------------------
  // submodules
  // --------------------------------------------------------------
  sfw_prescaler #(.DIV(PRESC_DIV)) u_presc (
    .aclk(aclk),
    .aresetn(aresetn),
    .divided_osc_clock(divided_osc_clock),
    .lk(lk)
  );

  sfw_reset_pulse #(.LEN(PULSE_LEN)) u_pulse (
    .aclk(aclk),
    .aresetn(aresetn),
    .lk(lk)
  );

  // --------------------------------------------------------------
  // option pin sampling
  // --------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      opt_s1_q <= 3'h0;
      opt_s2_q <= 3'h0;
    end else begin
      opt_s1_q <= {long_startup_option, halt_reset_option,
                   hw_watchdog_option};
      opt_s2_q <= opt_s1_q;
    end
  end

  assign hw_opt = opt_s2_q[0];
  assign halt_opt = opt_s2_q[1];
  assign long_opt = opt_s2_q[2];
  assign active_eff = active_q | hw_opt;

  // --------------------------------------------------------------
  // axi4-lite write channel
  // --------------------------------------------------------------
  // one write at a time; both readies stay low until the response goes
  assign do_write = !awready_q && !wready_q && !bvalid_q;
  assign wr_guard = do_write && wlane_q && sfw_sel(awaddr_q, `SFW_OFF_GUARD);
  assign wr_mode = do_write && wlane_q && sfw_sel(awaddr_q, `SFW_OFF_MODE);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= `SFW_RESP_OKAY;
      awaddr_q <= '0;
      wdata_q <= 8'h00;
      wlane_q <= 1'b0;
    end else begin
      if (awvalid && awready_q) begin
        awready_q <= 1'b0;
        awaddr_q <= awaddr;
      end
      if (wvalid && wready_q) begin
        wready_q <= 1'b0;
        wdata_q <= wdata[7:0];
        wlane_q <= wstrb[0];
      end
      if (do_write) begin
        bvalid_q <= 1'b1;
        bresp_q <= (sfw_sel(awaddr_q, `SFW_OFF_GUARD) ||
                    sfw_sel(awaddr_q, `SFW_OFF_MODE)) ?
                   `SFW_RESP_OKAY : `SFW_RESP_SLVERR;
      end else if (bvalid_q && bready) begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------
  // axi4-lite read channel
  // --------------------------------------------------------------
  assign tmin0 = 16'({8'h00, 2'b00, sfw_tb_lsb(mode_q[1:0])} +
                     {8'h00, `SFW_TMIN_OFFSET}) << `SFW_TMIN_SHIFT;

  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_ok = 1'b1;
    if (sfw_sel(araddr, `SFW_OFF_GUARD)) begin
      rd_mux[7:0] = {active_eff, count_q};
    end else if (sfw_sel(araddr, `SFW_OFF_MODE)) begin
      rd_mux[2:0] = mode_q;
    end else if (sfw_sel(araddr, `SFW_OFF_STATUS)) begin
      rd_mux[8:0] = {lk.busy, long_opt, halt_opt, hw_opt, st_q};
    end else if (sfw_sel(araddr, `SFW_OFF_BOUNDS)) begin
      rd_mux[5:0] = sfw_tb_msb(mode_q[1:0]);
      rd_mux[13:8] = sfw_tb_lsb(mode_q[1:0]);
      rd_mux[31:16] = tmin0;
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `SFW_RESP_OKAY;
    end else if (arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= rd_ok ? `SFW_RESP_OKAY : `SFW_RESP_SLVERR;
    end else if (rvalid_q && rready) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
    end
  end

  // --------------------------------------------------------------
  // control registers
  // --------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      active_q <= 1'b0;
    end else if (wr_guard && wdata_q[`SFW_GC_ACT_BIT]) begin
      active_q <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q <= `SFW_MODE_RESET;
    end else if (wr_mode) begin
      mode_q <= wdata_q[2:0];
    end
  end

  // --------------------------------------------------------------
  // counter
  // --------------------------------------------------------------
  // no slow or wait term here: those modes leave stepping untouched
  assign step = lk.tick && (st_q == SFW_ST_RUN ||
                            st_q == SFW_ST_HALT_ONCE);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q <= 7'(`SFW_GC_RESET);
    end else if (wr_guard) begin
      count_q <= wdata_q[6:0];
    end else if (step) begin
      count_q <= count_q - 1'b1;
    end
  end

  // --------------------------------------------------------------
  // halt handling
  // --------------------------------------------------------------
  assign wait_done = (wait_q == (long_opt ? 13'(`SFW_START_LONG - 1) :
                                            13'(`SFW_START_SHORT - 1)));

  always_comb begin
    st_d = st_q;
    case (st_q)
      SFW_ST_RUN: begin
        if (cpu_halt) begin
          if (mode_q[`SFW_MODE_OIE_BIT]) begin
            st_d = SFW_ST_ACT_HALT;
          end else if (!(halt_opt && active_eff)) begin
            st_d = SFW_ST_HALT_ONCE;
          end
        end
      end
      SFW_ST_HALT_ONCE: begin
        if (ext_irq) begin
          st_d = SFW_ST_RESTART;
        end else if (lk.tick) begin
          st_d = SFW_ST_HALT_STOP;
        end
      end
      SFW_ST_HALT_STOP: begin
        if (ext_irq) begin
          st_d = SFW_ST_RESTART;
        end
      end
      SFW_ST_ACT_HALT: begin
        if (ext_irq || osc_irq) begin
          st_d = SFW_ST_RUN;
        end
      end
      SFW_ST_RESTART: begin
        if (wait_done) begin
          st_d = SFW_ST_RUN;
        end
      end
      default: st_d = SFW_ST_RESTART;
    endcase
  end

  // every reset begins with the startup delay before stepping
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= SFW_ST_RESTART;
    end else begin
      st_q <= st_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wait_q <= 13'h0000;
    end else if (st_q != SFW_ST_RESTART) begin
      wait_q <= 13'h0000;
    end else begin
      wait_q <= wait_q + 1'b1;
    end
  end

  // --------------------------------------------------------------
  // trip and reset pin
  // --------------------------------------------------------------
  // halted states never trip on the countdown, which is why a halt without refresh wakes safe
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fire_q <= 1'b0;
    end else begin
      fire_q <= (step && st_q == SFW_ST_RUN && active_eff &&
                 count_q == `SFW_TRIP_FROM)
             || (wr_guard && !wdata_q[`SFW_GC_TOP_BIT] &&
                 (active_eff || wdata_q[`SFW_GC_ACT_BIT]))
             || (st_q == SFW_ST_RUN && cpu_halt &&
                 !mode_q[`SFW_MODE_OIE_BIT] && halt_opt &&
                 active_eff);
    end
  end

  assign lk.fire = fire_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reset_pin_n_q <= 1'b1;
    end else begin
      reset_pin_n_q <= !lk.busy;
    end
  end

  // --------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------
  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign reset_pin_n = reset_pin_n_q;

endmodule : sfw_watchdog

`default_nettype wire

// File: verilog/sfw_consts.svh
// constants of the software fault watchdog: offsets, fields, resets, timing
`ifndef SFW_CONSTS_SVH
`define SFW_CONSTS_SVH

`define SFW_ADDR_W 8
`define SFW_OFF_GUARD 8'h00
`define SFW_OFF_MODE 8'h04
`define SFW_OFF_STATUS 8'h08
`define SFW_OFF_BOUNDS 8'h0c

`define SFW_GC_ACT_BIT 7
`define SFW_GC_TOP_BIT 6
`define SFW_GC_RESET 8'h7f
`define SFW_MODE_RESET 3'h0
`define SFW_MODE_OIE_BIT 2

`define SFW_TRIP_FROM 7'h40
`define SFW_TRIP_TO 7'h3f

`define SFW_PRESC_CYCLES 16384
`define SFW_TMIN_OFFSET 8'h80
`define SFW_TMIN_SHIFT 6

`define SFW_CLK_NS 25
`define SFW_PULSE_NS 30000
`define SFW_PULSE_CYC (`SFW_PULSE_NS / `SFW_CLK_NS)
`define SFW_START_SHORT 256
`define SFW_START_LONG 4096

`define SFW_TB0_MSB 6'd4
`define SFW_TB0_LSB 6'd59
`define SFW_TB1_MSB 6'd8
`define SFW_TB1_LSB 6'd53
`define SFW_TB2_MSB 6'd20
`define SFW_TB2_LSB 6'd35
`define SFW_TB3_MSB 6'd49
`define SFW_TB3_LSB 6'd54

`define SFW_RESP_OKAY 2'h0
`define SFW_RESP_SLVERR 2'h2

`endif

// File: verilog/sfw_pkg.sv
// types of the software fault watchdog
`default_nettype none

package sfw_pkg;

  typedef enum logic [4:0] {
    SFW_ST_RUN = 5'b00001,
    SFW_ST_HALT_ONCE = 5'b00010,
    SFW_ST_HALT_STOP = 5'b00100,
    SFW_ST_ACT_HALT = 5'b01000,
    SFW_ST_RESTART = 5'b10000
  } sfw_state_t;

  typedef logic [1:0] sfw_tb_t;

endpackage : sfw_pkg

`default_nettype wire

// File: verilog/sfw_link_if.sv
// internal carrier between prescaler, core and reset pulse generator
`timescale 1ns/1ps
`default_nettype none

interface sfw_link_if;
  logic tick;
  logic fire;
  logic busy;

  modport presc (output tick);
  modport core (input tick, output fire, input busy);
  modport pulse (input fire, output busy);
endinterface : sfw_link_if

`default_nettype wire

// File: verilog/sfw_prescaler.sv
// free-running prescaler of the divided oscillator clock
`timescale 1ns/1ps
`default_nettype none
`include "sfw_consts.svh"

module sfw_prescaler #(
  parameter int unsigned DIV = `SFW_PRESC_CYCLES
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // oscillator pin
  input wire logic divided_osc_clock,
  // decrement tick
  sfw_link_if.presc lk
);

  localparam int W = $clog2(DIV);

  logic osc_s1_q;
  logic osc_s2_q;
  logic osc_s3_q;
  logic [W-1:0] cnt_q;
  logic edge_w;

  // --------------------------------------------------------------
  // pin sampling
  // --------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
      osc_s3_q <= 1'b0;
    end else begin
      osc_s1_q <= divided_osc_clock;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
    end
  end

  assign edge_w = osc_s2_q & ~osc_s3_q;

  // --------------------------------------------------------------
  // divider
  // --------------------------------------------------------------
  // never cleared by register writes, so a refresh lands at any phase
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= '0;
      lk.tick <= 1'b0;
    end else begin
      lk.tick <= 1'b0;
      if (edge_w) begin
        cnt_q <= cnt_q + 1'b1;
        lk.tick <= (cnt_q == W'(DIV - 1));
      end
    end
  end

endmodule : sfw_prescaler

`default_nettype wire

// File: verilog/sfw_reset_pulse.sv
// stretches a watchdog trip into a reset pin pulse
`timescale 1ns/1ps
`default_nettype none
`include "sfw_consts.svh"

module sfw_reset_pulse #(
  parameter int unsigned LEN = `SFW_PULSE_CYC
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // trip request and pulse state
  sfw_link_if.pulse lk
);

  localparam int W = $clog2(LEN + 1);

  logic [W-1:0] left_q;

  // --------------------------------------------------------------
  // pulse timer
  // --------------------------------------------------------------
  // a trip during a running pulse is absorbed, not restarted
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      left_q <= '0;
      lk.busy <= 1'b0;
    end else if (!lk.busy && lk.fire) begin
      left_q <= W'(LEN - 1);
      lk.busy <= 1'b1;
    end else if (lk.busy) begin
      left_q <= left_q - 1'b1;
      lk.busy <= (left_q != '0);
    end
  end

endmodule : sfw_reset_pulse

`default_nettype wire

// File: verification/sfw_watchdog_props.sv
// port assertions of the software fault watchdog
`timescale 1ns/1ps
`default_nettype none
`include "sfw_consts.svh"

module sfw_watchdog_props #(
  parameter int unsigned PULSE_LEN = `SFW_PULSE_CYC
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [`SFW_ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  // reset pin
  input wire logic reset_pin_n
);
  // ----------------------------------------
  // low time of the reset pin
  // ----------------------------------------
  int unsigned low_q;
  always_ff @(posedge aclk) begin
    if (!aresetn || reset_pin_n) begin
      low_q <= 0;
    end else begin
      low_q <= low_q + 1;
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // ----------------------------------------
  // properties
  // ----------------------------------------
  property p_b_after_take;
    awvalid && awready && wvalid && wready |-> ##2 bvalid;
  endproperty
  a_b_after_take: assert property (p_b_after_take) else $error("late b");
  property p_r_after_take;
    arvalid && arready |=> rvalid;
  endproperty
  a_r_after_take: assert property (p_r_after_take) else $error("late r");
  property p_b_hold;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("b dropped");
  property p_r_hold;
    rvalid && !rready |=> rvalid && $stable(rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("r dropped");
  property p_w_refuse;
    bvalid |-> !awready && !wready;
  endproperty
  a_w_refuse: assert property (p_w_refuse) else $error("write overlap");
  property p_r_refuse;
    rvalid |-> !arready;
  endproperty
  a_r_refuse: assert property (p_r_refuse) else $error("read overlap");
  property p_after_reset;
    $rose(aresetn) |-> reset_pin_n && awready && arready && !bvalid;
  endproperty
  a_after_reset: assert property (p_after_reset) else $error("bad reset");
  property p_sw_trip;
    awvalid && awready && wvalid && wready && wstrb[0] && reset_pin_n &&
      awaddr == `SFW_OFF_GUARD && wdata[7:6] == 2'b10 |-> ##[2:6] !reset_pin_n;
  endproperty
  a_sw_trip: assert property (p_sw_trip) else $error("no soft reset");
  property p_pulse_len;
    $rose(reset_pin_n) |-> low_q >= PULSE_LEN && low_q <= PULSE_LEN + 1;
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("pulse length");
  property p_pulse_end;
    !reset_pin_n |-> low_q <= PULSE_LEN + 1;
  endproperty
  a_pulse_end: assert property (p_pulse_end) else $error("pulse stuck");
endmodule : sfw_watchdog_props

bind sfw_watchdog sfw_watchdog_props #(.PULSE_LEN(PULSE_LEN)) u_props (
  .aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
  .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .rvalid, .rready,
  .rdata, .reset_pin_n
);

`default_nettype wire

// File: verification/sfw_watchdog_tb_top.sv
// self-checking testbench of the software fault watchdog
`timescale 1ns/1ps
`default_nettype none
`include "sfw_consts.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fails++; \
  $display("BAD t=%0t got %h exp %h", $time, (a), (b)); end end

module sfw_watchdog_tb_top;
  import sfw_pkg::*;
  // short counts keep the run small
  localparam int unsigned DIV = 16;
  localparam int unsigned PL = 4;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, osc = 0, hw_opt = 0, halt_opt = 0;
  logic cpu_halt = 0, ext_irq = 0, osc_irq = 0, long_opt = 0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [3:0] wstrb = 4'h0;
  logic [1:0] bresp, rresp, r;
  logic awready, wready, bvalid, arready, rvalid, reset_pin_n;
  int fails = 0, check_count = 0, n;

  sfw_watchdog #(.PRESC_DIV(DIV), .PULSE_LEN(PL)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .divided_osc_clock(osc), .hw_watchdog_option(hw_opt),
    .halt_reset_option(halt_opt), .long_startup_option(long_opt),
    .cpu_halt(cpu_halt), .ext_irq(ext_irq), .osc_irq(osc_irq),
    .reset_pin_n(reset_pin_n)
  );

  // ----------------------------------------
  // clocks, oscillator pin, watchdog
  // ----------------------------------------
  always #12.5 aclk = ~aclk;
  always @(posedge aclk) osc <= ~osc;
  initial begin
    #(25 * 30000);
    fails++;
    conclude();
  end

  // ----------------------------------------
  // bus and helper tasks
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic ta, tw, tb;
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'h1;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bready && bvalid;
      if (tb) r = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 0;
      if (tw) wvalid <= 0;
      if (tb) bready <= 0;
    end while (awvalid || wvalid || bready);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    logic ta, tr;
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(negedge aclk);
      ta = arvalid && arready;
      tr = rready && rvalid;
      if (tr) begin
        d = rdata;
        r = rresp;
      end
      @(posedge aclk);
      if (ta) arvalid <= 0;
      if (tr) rready <= 0;
    end while (arvalid || rready);
  endtask : rd

  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask : cyc

  // counts cycles until the reset pin goes low, k when it never does
  task automatic wait_low(input int k);
    n = 0;
    while (reset_pin_n !== 1'b0 && n < k) begin
      @(negedge aclk);
      n++;
    end
    @(posedge aclk);
  endtask : wait_low

  task automatic do_reset();
    aresetn <= 0;
    cyc(3);
    aresetn <= 1;
  endtask : do_reset

  task automatic pulse(input int k);
    cpu_halt <= (k == 0);
    ext_irq <= (k == 1);
    osc_irq <= (k == 2);
    cyc(1);
    cpu_halt <= 0;
    ext_irq <= 0;
    osc_irq <= 0;
    cyc(1);
  endtask : pulse

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic s_reset_map();
    rd(`SFW_OFF_GUARD);
    `CHK(d, 32'h7f)
    rd(8'h10);
    `CHK({r, d}, {`SFW_RESP_SLVERR, 32'h0})
    wr(8'h10, 32'hff);
    `CHK(r, `SFW_RESP_SLVERR)
    cyc(260);
  endtask : s_reset_map

  task automatic s_free_run();
    wr(`SFW_OFF_GUARD, 32'h48);
    cyc(5 * 2 * DIV);
    rd(`SFW_OFF_GUARD);
    `CHK(d[7:0] >= 8'h42 && d[7:0] <= 8'h43, 1'b1)
    wait_low(5 * 2 * DIV);
    `CHK(n, 5 * 2 * DIV)
  endtask : s_free_run

  task automatic s_timeout();
    wr(`SFW_OFF_GUARD, 32'hc2);
    rd(`SFW_OFF_GUARD);
    `CHK(d[7:0] == 8'hc2 || d[7:0] == 8'hc1, 1'b1)
    wait_low(200);
    `CHK(n >= 50 && n <= 100, 1'b1)
    cyc(PL + 4);
    do_reset();
    rd(`SFW_OFF_GUARD);
    `CHK(d[7], 1'b0)
    cyc(260);
  endtask : s_timeout

  task automatic s_sticky();
    wr(`SFW_OFF_GUARD, 32'hff);
    wr(`SFW_OFF_GUARD, 32'h7f);
    rd(`SFW_OFF_GUARD);
    `CHK(d[7], 1'b1)
    wr(`SFW_OFF_GUARD, 32'h80);
    wait_low(10);
    `CHK(n < 10, 1'b1)
    cyc(PL + 4);
    do_reset();
    cyc(260);
  endtask : s_sticky

  task automatic s_halt();
    logic [31:0] g;
    wr(`SFW_OFF_GUARD, 32'hff);
    halt_opt <= 1;
    cyc(4);
    pulse(0);
    wait_low(10);
    `CHK(n < 10, 1'b1)
    cyc(PL + 4);
    halt_opt <= 0;
    do_reset();
    cyc(260);
    wr(`SFW_OFF_GUARD, 32'hff);
    pulse(0);
    rd(`SFW_OFF_STATUS);
    `CHK(d[4:0], 5'h02)
    cyc(2 * 2 * DIV);
    rd(`SFW_OFF_STATUS);
    `CHK(d[4:0], 5'h04)
    rd(`SFW_OFF_GUARD);
    g = d;
    wait_low(4 * 2 * DIV);
    rd(`SFW_OFF_GUARD);
    `CHK({n, d}, {4 * 2 * DIV, g})
    pulse(1);
    cyc(240);
    rd(`SFW_OFF_STATUS);
    `CHK(d[4:0], 5'h10)
    cyc(20);
    rd(`SFW_OFF_STATUS);
    `CHK(d[4:0], 5'h01)
    wr(`SFW_OFF_MODE, 32'h4);
    pulse(0);
    rd(`SFW_OFF_GUARD);
    g = d;
    wait_low(4 * 2 * DIV);
    rd(`SFW_OFF_GUARD);
    `CHK({n, d}, {4 * 2 * DIV, g})
    pulse(2);
    rd(`SFW_OFF_STATUS);
    `CHK(d[4:0], 5'h01)
    wr(`SFW_OFF_MODE, 32'h0);
  endtask : s_halt

  task automatic s_bounds();
    logic [5:0] msb [4] = '{`SFW_TB0_MSB, `SFW_TB1_MSB, `SFW_TB2_MSB,
      `SFW_TB3_MSB};
    logic [5:0] lsb [4] = '{`SFW_TB0_LSB, `SFW_TB1_LSB, `SFW_TB2_LSB,
      `SFW_TB3_LSB};
    logic [15:0] tmin;
    for (int i = 0; i < 4; i++) begin
      tmin = ({10'h0, lsb[i]} + 16'h0080) * 16'h0040;
      wr(`SFW_OFF_MODE, i);
      rd(`SFW_OFF_BOUNDS);
      `CHK(d, {tmin, 2'h0, lsb[i], 2'h0, msb[i]})
    end
  endtask : s_bounds

  // long startup: restart delay after reset follows the option pin
  task automatic s_long_start();
    long_opt <= 1;
    do_reset();
    cyc(4000);
    rd(`SFW_OFF_STATUS);
    `CHK(d[4:0], 5'h10)
    cyc(100);
    rd(`SFW_OFF_STATUS);
    `CHK(d[4:0], 5'h01)
    long_opt <= 0;
  endtask : s_long_start

  // fresh reset first so the activation bit is known clear
  task automatic s_hw_option();
    do_reset();
    hw_opt <= 1;
    cyc(4);
    wr(`SFW_OFF_GUARD, 32'h7f);
    rd(`SFW_OFF_GUARD);
    `CHK(d[7], 1'b1)
    wr(`SFW_OFF_GUARD, 32'h3f);
    wait_low(10);
    `CHK(n < 10, 1'b1)
    cyc(PL + 4);
    hw_opt <= 0;
    do_reset();
  endtask : s_hw_option

  task automatic conclude();
    if (fails == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude

  initial begin
    do_reset();
    s_reset_map();
    s_free_run();
    s_timeout();
    s_sticky();
    s_halt();
    s_bounds();
    s_long_start();
    s_hw_option();
    conclude();
  end
endmodule : sfw_watchdog_tb_top

`default_nettype wire
